// file: design/lodpc_pkg.sv
// constants and carriers for the input-cleanup loop divider and pump control bank
package lodpc_pkg;

   // register port address and data widths, divider and pump current widths
   localparam int unsigned ADDR_W = 16;
   localparam int unsigned DATA_W = 8;
   localparam int unsigned DIV_W  = 10;
   localparam int unsigned CP_W   = 7;

   // register offsets
   localparam logic [15:0] OFS_TRANSFER       = 16'h000f;
   localparam logic [15:0] OFS_FIRST_DIV_LO   = 16'h0100;
   localparam logic [15:0] OFS_FIRST_DIV_HI   = 16'h0101;
   localparam logic [15:0] OFS_SECOND_DIV_LO  = 16'h0102;
   localparam logic [15:0] OFS_SECOND_DIV_HI  = 16'h0103;
   localparam logic [15:0] OFS_LOOP_FB_DIV_LO = 16'h0104;
   localparam logic [15:0] OFS_LOOP_FB_DIV_HI = 16'h0105;
   localparam logic [15:0] OFS_PUMP_CUR_HOLD  = 16'h0106;
   localparam logic [15:0] OFS_PUMP_MODE_AUTO = 16'h0107;
   localparam logic [15:0] OFS_RX_CTRL        = 16'h0108;

   // number of staged registers, starting at the first divider low byte
   localparam int unsigned NUM_REGS = 9;

   // writable bit masks, reserved bits clear
   localparam logic [7:0] MASK_DIV_LO   = 8'hff;
   localparam logic [7:0] MASK_DIV_HI   = 8'h03;
   localparam logic [7:0] MASK_CUR_HOLD = 8'hff;
   localparam logic [7:0] MASK_MODE     = 8'h23;
   localparam logic [7:0] MASK_RX       = 8'hfc;
   localparam logic [7:0] MASK_TRANSFER = 8'h01;

   // field positions
   localparam int unsigned BIT_TRANSFER     = 0;
   localparam int unsigned BIT_FORCE_HOLD   = 7;
   localparam int unsigned BIT_AUTO_HOLD_DIS = 5;
   localparam int unsigned BIT_FD_PD        = 7;
   localparam int unsigned BIT_SECOND_DIFF  = 6;
   localparam int unsigned BIT_FIRST_DIFF   = 5;
   localparam int unsigned BIT_SECOND_RX_EN = 4;
   localparam int unsigned BIT_FIRST_RX_EN  = 3;
   localparam int unsigned BIT_OSC_PD_CTRL  = 2;

   // pump mode codes
   localparam logic [1:0] CP_MODE_TRISTATE = 2'h0;
   localparam logic [1:0] CP_MODE_DOWN     = 2'h1;
   localparam logic [1:0] CP_MODE_UP       = 2'h2;
   localparam logic [1:0] CP_MODE_NORMAL   = 2'h3;

   // reset values
   localparam logic [7:0] RST_REG = 8'h00;
   localparam logic [9:0] RST_RATIO = 10'h001;

   // register port request
   typedef struct packed {
      logic        wr;
      logic        rd;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } lodpc_req_s;

   // charge pump controls
   typedef struct packed {
      logic       force_hold;
      logic [6:0] current;
      logic       auto_hold_dis;
      logic       pump_up;
      logic       pump_down;
      logic       hiz;
   } lodpc_pump_s;

endpackage

// file: design/lodpc_ratio_div.sv
// programmable event divider, one output pulse every n input events
`timescale 1ns/1ps
module lodpc_ratio_div #(
   parameter int unsigned DIV_W = 10
) (
   // clock and reset
   input  wire logic             ref_clk_i,
   input  wire logic             resetn_i,
   // ratio and events
   input  wire logic [DIV_W-1:0] ratio_i,
   input  wire logic             tick_i,
   // divided output
   output logic                  pulse_o
);

   logic [DIV_W-1:0] ratio_q;
   logic [DIV_W-1:0] cnt_q;

   // codes zero and one both mean divide by one
   function automatic logic [DIV_W-1:0] eff_ratio(input logic [DIV_W-1:0] r);
      eff_ratio = (r < DIV_W'(2)) ? DIV_W'(1) : r;
   endfunction

   // count input events, wrap at ratio, take new ratio only at wrap
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         cnt_q   <= '0;
         ratio_q <= DIV_W'(1);
         pulse_o <= 1'b0;
      end else begin
         pulse_o <= 1'b0;
         if (tick_i) begin
            if (cnt_q >= ratio_q - DIV_W'(1)) begin
               cnt_q   <= '0;
               pulse_o <= 1'b1;
               ratio_q <= eff_ratio(ratio_i);
            end else begin
               cnt_q <= cnt_q + DIV_W'(1);
            end
         end
      end
   end

endmodule // lodpc_ratio_div

// file: design/lodpc_top.sv
// register bank and dividers of the input-cleanup loop
//
// Summary of operation
// - first reference divider is ten bits: low byte 0x0100, bits [1:0] of 0x0101.
// - second reference divider is ten bits: low byte 0x0102, bits [1:0] of 0x0103.
// - loop feedback divider is ten bits: low byte 0x0104, bits [1:0] of 0x0105.
// - dividers cover 1 to 1023; codes zero and one both divide by one.
// - bit 7 of 0x0106 forces holdover and puts pump output in high impedance.
// - bits [6:0] of 0x0106 set pump current, about 0.5 uA a step.
// - bit 5 of 0x0107 set disables automatic holdover; clear keeps it enabled.
// - bits [1:0] of 0x0107: 00 tristate default, 01 down, 10 up, 11 normal.
// - bit 7 of 0x0108 enables frequency detector power-down; resets to zero.
// - bit 6 of 0x0108 selects differential second reference input; resets clear.
// - bit 5 of 0x0108 selects differential first reference input; resets clear.
// - bit 4 of 0x0108 enables second reference receiver; powered down at reset.
// - bit 3 of 0x0108 enables first reference receiver; powered down at reset.
// - bit 2 of 0x0108 enables software power-down control of oscillator receivers.
// - with that bit clear, the reset state, both oscillator receivers stay enabled.
// - writing one to transfer strobe moves staged values to active; bit self-clears.
`timescale 1ns/1ps
module lodpc_top #(
   parameter int unsigned DIV_W = lodpc_pkg::DIV_W
) (
   // clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                resetn_i,
   // serial control port register access
   input  wire lodpc_pkg::lodpc_req_s req_i,
   output logic [7:0]               rdata_o,
   output logic                     rvalid_o,
   // reference and feedback clock pins
   input  wire logic                first_reference_input_i,
   input  wire logic                second_reference_input_i,
   input  wire logic                loop_feedback_input_i,
   // divided outputs
   output logic                     first_reference_divider_o,
   output logic                     second_reference_divider_o,
   output logic                     loop_feedback_divider_o,
   // active ratios
   output logic [DIV_W-1:0]         first_ratio_o,
   output logic [DIV_W-1:0]         second_ratio_o,
   output logic [DIV_W-1:0]         loop_fb_ratio_o,
   // charge pump controls
   output lodpc_pkg::lodpc_pump_s   pump_o,
   // receiver controls
   output logic                     freq_det_pd_en_o,
   output logic                     second_ref_diff_o,
   output logic                     first_ref_diff_o,
   output logic                     second_ref_rx_en_o,
   output logic                     first_ref_rx_en_o,
   output logic                     osc_pd_ctrl_en_o,
   output logic                     osc_rx_force_on_o
);

   localparam int unsigned NREG = lodpc_pkg::NUM_REGS;
   localparam int unsigned NDIV = 3;

   // bank slots, offset less the first divider low byte
   localparam int unsigned S_FIRST_LO  = 0;
   localparam int unsigned S_FIRST_HI  = 1;
   localparam int unsigned S_SECOND_LO = 2;
   localparam int unsigned S_SECOND_HI = 3;
   localparam int unsigned S_LOOP_LO   = 4;
   localparam int unsigned S_LOOP_HI   = 5;
   localparam int unsigned S_PUMP_CUR  = 6;
   localparam int unsigned S_PUMP_MODE = 7;
   localparam int unsigned S_RX        = 8;

   // staged and active register copies
   logic [7:0] stage_q [NREG];
   logic [7:0] act_q   [NREG];
   logic       transfer_q;

   // request decode
   logic       wr_bank;
   logic       rd_bank;
   logic       wr_xfer;
   logic       rd_xfer;
   logic [3:0] slot;

   // active fields by name
   logic       force_hold_a;
   logic [6:0] pump_cur_a;
   logic       auto_hold_dis_a;
   logic [1:0] pump_mode_a;
   logic [7:0] rx_ctrl_a;

   // pin synchronisers and edge detect
   logic [NDIV-1:0] pin_raw;
   logic [NDIV-1:0] sync1_q;
   logic [NDIV-1:0] sync2_q;
   logic [NDIV-1:0] prev_q;
   logic [NDIV-1:0] tick;
   logic [NDIV-1:0] rx_gate;
   logic [NDIV-1:0] div_pulse;
   logic [DIV_W-1:0] ratio [NDIV];

   // address decode shared by writes and reads
   function automatic logic in_bank(input logic [15:0] a);
      in_bank = (a >= lodpc_pkg::OFS_FIRST_DIV_LO) && (a <= lodpc_pkg::OFS_RX_CTRL);
   endfunction

   function automatic logic [3:0] bank_idx(input logic [15:0] a);
      logic [15:0] d;
      d = a - lodpc_pkg::OFS_FIRST_DIV_LO;
      bank_idx = d[3:0];
   endfunction

   // writable bits per offset, reserved bits masked
   function automatic logic [7:0] wmask(input logic [15:0] a);
      case (a)
         lodpc_pkg::OFS_FIRST_DIV_LO:   wmask = lodpc_pkg::MASK_DIV_LO;
         lodpc_pkg::OFS_FIRST_DIV_HI:   wmask = lodpc_pkg::MASK_DIV_HI;
         lodpc_pkg::OFS_SECOND_DIV_LO:  wmask = lodpc_pkg::MASK_DIV_LO;
         lodpc_pkg::OFS_SECOND_DIV_HI:  wmask = lodpc_pkg::MASK_DIV_HI;
         lodpc_pkg::OFS_LOOP_FB_DIV_LO: wmask = lodpc_pkg::MASK_DIV_LO;
         lodpc_pkg::OFS_LOOP_FB_DIV_HI: wmask = lodpc_pkg::MASK_DIV_HI;
         lodpc_pkg::OFS_PUMP_CUR_HOLD:  wmask = lodpc_pkg::MASK_CUR_HOLD;
         lodpc_pkg::OFS_PUMP_MODE_AUTO: wmask = lodpc_pkg::MASK_MODE;
         lodpc_pkg::OFS_RX_CTRL:        wmask = lodpc_pkg::MASK_RX;
         lodpc_pkg::OFS_TRANSFER:       wmask = lodpc_pkg::MASK_TRANSFER;
         default:                       wmask = 8'h00;
      endcase
   endfunction

   // ten bit ratio from a low byte and the two low bits of the high byte
   function automatic logic [DIV_W-1:0] ratio_of(input logic [7:0] lo, input logic [7:0] hi);
      ratio_of = DIV_W'({hi[1:0], lo});
   endfunction

   // request decode shared by staging, strobe and read
   assign slot    = bank_idx(req_i.addr);
   assign wr_bank = req_i.wr && in_bank(req_i.addr);
   assign rd_bank = req_i.rd && in_bank(req_i.addr);
   assign wr_xfer = req_i.wr && (req_i.addr == lodpc_pkg::OFS_TRANSFER) && req_i.wdata[lodpc_pkg::BIT_TRANSFER];
   assign rd_xfer = req_i.rd && (req_i.addr == lodpc_pkg::OFS_TRANSFER);

   // staged registers take masked writes
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NREG; i++) begin
            stage_q[i] <= lodpc_pkg::RST_REG;
         end
      end else if (wr_bank) begin
         stage_q[slot] <= req_i.wdata & wmask(req_i.addr);
      end
   end

   // transfer strobe, a new write of one wins over the self-clear
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         transfer_q <= 1'b0;
      end else if (wr_xfer) begin
         transfer_q <= 1'b1;
      end else begin
         transfer_q <= 1'b0;
      end
   end

   // active registers loaded from staged copies on transfer
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         for (int i = 0; i < NREG; i++) begin
            act_q[i] <= lodpc_pkg::RST_REG;
         end
      end else if (transfer_q) begin
         for (int i = 0; i < NREG; i++) begin
            act_q[i] <= stage_q[i];
         end
      end
   end

   // read answer strobe, one cycle after each read
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rvalid_o <= 1'b0;
      end else begin
         rvalid_o <= req_i.rd;
      end
   end

   // read data, staged values and strobe state, zero when idle
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         rdata_o <= 8'h00;
      end else if (!req_i.rd) begin
         rdata_o <= 8'h00;
      end else if (rd_bank) begin
         rdata_o <= stage_q[slot] & wmask(req_i.addr);
      end else if (rd_xfer) begin
         rdata_o <= {7'h00, transfer_q};
      end else begin
         rdata_o <= 8'h00;
      end
   end

   // ten bit ratios from low byte and two upper bits
   assign ratio[0] = ratio_of(act_q[S_FIRST_LO], act_q[S_FIRST_HI]);
   assign ratio[1] = ratio_of(act_q[S_SECOND_LO], act_q[S_SECOND_HI]);
   assign ratio[2] = ratio_of(act_q[S_LOOP_LO], act_q[S_LOOP_HI]);

   // active fields of the pump and receiver slots
   assign force_hold_a    = act_q[S_PUMP_CUR][lodpc_pkg::BIT_FORCE_HOLD];
   assign pump_cur_a      = act_q[S_PUMP_CUR][6:0];
   assign auto_hold_dis_a = act_q[S_PUMP_MODE][lodpc_pkg::BIT_AUTO_HOLD_DIS];
   assign pump_mode_a     = act_q[S_PUMP_MODE][1:0];
   assign rx_ctrl_a       = act_q[S_RX];

   // ratio outputs
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         first_ratio_o   <= '0;
         second_ratio_o  <= '0;
         loop_fb_ratio_o <= '0;
      end else begin
         first_ratio_o   <= ratio[0];
         second_ratio_o  <= ratio[1];
         loop_fb_ratio_o <= ratio[2];
      end
   end

   // charge pump controls
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         pump_o.force_hold    <= 1'b0;
         pump_o.current       <= 7'h00;
         pump_o.auto_hold_dis <= 1'b0;
         pump_o.hiz           <= 1'b1;
         pump_o.pump_up       <= 1'b0;
         pump_o.pump_down     <= 1'b0;
      end else begin
         pump_o.force_hold    <= force_hold_a;
         pump_o.current       <= pump_cur_a;
         pump_o.auto_hold_dis <= auto_hold_dis_a;
         // forced holdover overrides the mode field
         if (force_hold_a) begin
            pump_o.hiz       <= 1'b1;
            pump_o.pump_up   <= 1'b0;
            pump_o.pump_down <= 1'b0;
         end else begin
            case (pump_mode_a)
               lodpc_pkg::CP_MODE_TRISTATE: begin
                  pump_o.hiz       <= 1'b1;
                  pump_o.pump_up   <= 1'b0;
                  pump_o.pump_down <= 1'b0;
               end
               lodpc_pkg::CP_MODE_DOWN: begin
                  pump_o.hiz       <= 1'b0;
                  pump_o.pump_up   <= 1'b0;
                  pump_o.pump_down <= 1'b1;
               end
               lodpc_pkg::CP_MODE_UP: begin
                  pump_o.hiz       <= 1'b0;
                  pump_o.pump_up   <= 1'b1;
                  pump_o.pump_down <= 1'b0;
               end
               lodpc_pkg::CP_MODE_NORMAL: begin
                  pump_o.hiz       <= 1'b0;
                  pump_o.pump_up   <= 1'b1;
                  pump_o.pump_down <= 1'b1;
               end
               default: begin
                  pump_o.hiz       <= 1'b1;
                  pump_o.pump_up   <= 1'b0;
                  pump_o.pump_down <= 1'b0;
               end
            endcase
         end
      end
   end

   // input receiver controls
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         freq_det_pd_en_o   <= 1'b0;
         second_ref_diff_o  <= 1'b0;
         first_ref_diff_o   <= 1'b0;
         second_ref_rx_en_o <= 1'b0;
         first_ref_rx_en_o  <= 1'b0;
         osc_pd_ctrl_en_o   <= 1'b0;
         osc_rx_force_on_o  <= 1'b1;
      end else begin
         freq_det_pd_en_o   <= rx_ctrl_a[lodpc_pkg::BIT_FD_PD];
         second_ref_diff_o  <= rx_ctrl_a[lodpc_pkg::BIT_SECOND_DIFF];
         first_ref_diff_o   <= rx_ctrl_a[lodpc_pkg::BIT_FIRST_DIFF];
         second_ref_rx_en_o <= rx_ctrl_a[lodpc_pkg::BIT_SECOND_RX_EN];
         first_ref_rx_en_o  <= rx_ctrl_a[lodpc_pkg::BIT_FIRST_RX_EN];
         osc_pd_ctrl_en_o   <= rx_ctrl_a[lodpc_pkg::BIT_OSC_PD_CTRL];
         osc_rx_force_on_o  <= ~rx_ctrl_a[lodpc_pkg::BIT_OSC_PD_CTRL];
      end
   end

   // powered-down receivers pass no edges
   assign pin_raw = {loop_feedback_input_i, second_reference_input_i, first_reference_input_i};
   assign rx_gate = {1'b1,
                     rx_ctrl_a[lodpc_pkg::BIT_SECOND_RX_EN],
                     rx_ctrl_a[lodpc_pkg::BIT_FIRST_RX_EN]};

   // two-flop synchronisers, edge detect on the second stage only
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         sync1_q <= '0;
         sync2_q <= '0;
         prev_q  <= '0;
      end else begin
         sync1_q <= pin_raw;
         sync2_q <= sync1_q;
         prev_q  <= sync2_q;
      end
   end

   // rising edge of each synchronised pin, the two reference pins gated by their receivers
   assign tick = sync2_q & ~prev_q & rx_gate;

   // one divider per input
   for (genvar g = 0; g < NDIV; g++) begin : g_div
      lodpc_ratio_div #(
         .DIV_W (DIV_W)
      ) u_div (
         .ref_clk_i (ref_clk_i),
         .resetn_i  (resetn_i),
         .ratio_i   (ratio[g]),
         .tick_i    (tick[g]),
         .pulse_o   (div_pulse[g])
      );
   end

   // divided pulse outputs
   always_ff @(posedge ref_clk_i or negedge resetn_i) begin
      if (!resetn_i) begin
         first_reference_divider_o  <= 1'b0;
         second_reference_divider_o <= 1'b0;
         loop_feedback_divider_o    <= 1'b0;
      end else begin
         first_reference_divider_o  <= div_pulse[0];
         second_reference_divider_o <= div_pulse[1];
         loop_feedback_divider_o    <= div_pulse[2];
      end
   end

endmodule // lodpc_top

// file: sim/lodpc_monitor.sv
// assertion checker for the loop divider and pump control bank
`timescale 1ns/1ps
module lodpc_monitor #(
   parameter int unsigned DIV_W = 10
) (
   // clock and reset
   input wire logic                  ref_clk_i,
   input wire logic                  resetn_i,
   // register port
   input wire lodpc_pkg::lodpc_req_s req_i,
   input wire logic [7:0]            rdata_o,
   input wire logic                  rvalid_o,
   // divider side
   input wire logic                  first_reference_divider_o,
   input wire logic                  second_reference_divider_o,
   input wire logic                  loop_feedback_divider_o,
   input wire logic [DIV_W-1:0]      first_ratio_o,
   // controls
   input wire lodpc_pkg::lodpc_pump_s pump_o,
   input wire logic                  second_ref_rx_en_o,
   input wire logic                  first_ref_rx_en_o,
   input wire logic                  osc_pd_ctrl_en_o,
   input wire logic                  osc_rx_force_on_o
);
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!resetn_i);
   logic xfer;
   assign xfer = req_i.wr && (req_i.addr == lodpc_pkg::OFS_TRANSFER) && req_i.wdata[0];

   a_read_answer: assert property (req_i.rd |=> rvalid_o) else $error("read not answered next cycle");
   a_read_nocause: assert property (!req_i.rd |=> !rvalid_o) else $error("read answer without request");
   a_rdata_idle: assert property (!rvalid_o |-> rdata_o == 8'h00) else $error("read data not zero when idle");
   a_ratio_on_xfer: assert property ($changed(first_ratio_o) |-> $past(xfer, 2) || $past(xfer, 3) || $past(xfer, 4))
      else $error("active ratio changed without transfer");
   a_force_hold_hiz: assert property (pump_o.force_hold |-> pump_o.hiz && !pump_o.pump_up && !pump_o.pump_down)
      else $error("forced holdover does not tristate pump");
   a_tristate_quiet: assert property (pump_o.hiz |-> !pump_o.pump_up && !pump_o.pump_down)
      else $error("pump drives while tristated");
   a_normal_drive: assert property (pump_o.pump_up && pump_o.pump_down |-> !pump_o.hiz)
      else $error("normal mode left tristated");
   a_osc_default: assert property (osc_rx_force_on_o == !osc_pd_ctrl_en_o)
      else $error("oscillator receivers not held on");
   a_first_rx_gate: assert property (!first_ref_rx_en_o [*8] |-> !first_reference_divider_o)
      else $error("first divider pulsed with receiver off");
   a_second_rx_gate: assert property (!second_ref_rx_en_o [*8] |-> !second_reference_divider_o)
      else $error("second divider pulsed with receiver off");
   a_pulse_single: assert property (loop_feedback_divider_o |=> !loop_feedback_divider_o)
      else $error("divider pulse longer than one cycle");

   c_transfer: cover property (xfer ##4 1);
   c_normal: cover property (pump_o.pump_up && pump_o.pump_down);
   c_first_pulse: cover property (first_reference_divider_o);
endmodule // lodpc_monitor

bind lodpc_top lodpc_monitor #(.DIV_W(DIV_W)) i_lodpc_monitor (.ref_clk_i(ref_clk_i), .resetn_i(resetn_i),
   .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o), .first_reference_divider_o(first_reference_divider_o),
   .second_reference_divider_o(second_reference_divider_o), .loop_feedback_divider_o(loop_feedback_divider_o),
   .first_ratio_o(first_ratio_o), .pump_o(pump_o), .second_ref_rx_en_o(second_ref_rx_en_o),
   .first_ref_rx_en_o(first_ref_rx_en_o), .osc_pd_ctrl_en_o(osc_pd_ctrl_en_o), .osc_rx_force_on_o(osc_rx_force_on_o));

// file: sim/testbench.sv
// self-checking bench for the loop divider and pump control bank
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin n_checks++; if ((got) !== (exp)) begin failures++; \
   $display("[FAIL] %s expected %h seen %h", nm, exp, got); end end
module testbench;
   logic                   ref_clk_i = 1'b0;
   logic                   resetn_i  = 1'b0;
   lodpc_pkg::lodpc_req_s  req_i     = '0;
   logic [2:0]             pins      = 3'h0;
   logic [7:0]             rdata_o;
   logic                   rvalid_o;
   logic [2:0]             div_o;
   logic [9:0]             first_ratio_o, second_ratio_o, loop_fb_ratio_o;
   lodpc_pkg::lodpc_pump_s pump_o;
   logic [6:0]             rx_o;
   logic [7:0]             regs [9] = '{default: 8'h00};
   logic [9:0]             codes [5];
   int                     failures = 0;
   int                     n_checks = 0;
   int                     cyc = 0;
   int                     cnt [3] = '{0, 0, 0};
   int                     b [3];
   int                     n;
   integer                 seed = 32'h58ee86ac;

   lodpc_top #(.DIV_W(10)) i_lodpc_top (
      .ref_clk_i(ref_clk_i), .resetn_i(resetn_i), .req_i(req_i), .rdata_o(rdata_o), .rvalid_o(rvalid_o),
      .first_reference_input_i(pins[0]), .second_reference_input_i(pins[1]), .loop_feedback_input_i(pins[2]),
      .first_reference_divider_o(div_o[0]), .second_reference_divider_o(div_o[1]),
      .loop_feedback_divider_o(div_o[2]), .first_ratio_o(first_ratio_o), .second_ratio_o(second_ratio_o),
      .loop_fb_ratio_o(loop_fb_ratio_o), .pump_o(pump_o), .freq_det_pd_en_o(rx_o[6]), .second_ref_diff_o(rx_o[5]),
      .first_ref_diff_o(rx_o[4]), .second_ref_rx_en_o(rx_o[3]), .first_ref_rx_en_o(rx_o[2]),
      .osc_pd_ctrl_en_o(rx_o[1]), .osc_rx_force_on_o(rx_o[0]));

   initial begin
      forever #25 ref_clk_i = ~ref_clk_i;
   end

   always @(posedge ref_clk_i) begin
      for (int k = 0; k < 3; k++) cnt[k] <= cnt[k] + int'(div_o[k]);
      cyc <= cyc + 1;
      if (cyc == 80000) begin
         failures++;
         finish_test();
      end
   end

   function automatic logic [7:0] msk(input int i);
      case (i)
         1, 3, 5: return 8'h03;
         7: return 8'h23;
         8: return 8'hfc;
         default: return 8'hff;
      endcase
   endfunction

   function automatic lodpc_pkg::lodpc_pump_s exp_pump(input logic [7:0] c, input logic [7:0] m);
      lodpc_pkg::lodpc_pump_s p;
      p.force_hold    = c[7];
      p.current       = c[6:0];
      p.auto_hold_dis = m[5];
      p.pump_up       = ~c[7] & m[1];
      p.pump_down     = ~c[7] & m[0];
      p.hiz           = c[7] | (m[1:0] == 2'b00);
      return p;
   endfunction

   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge ref_clk_i);
      req_i <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      @(posedge ref_clk_i);
      req_i.wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge ref_clk_i);
      req_i <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
      @(posedge ref_clk_i);
      req_i.rd <= 1'b0;
      #1;
      `CHK("rvalid", 1'b1, rvalid_o)
      `CHK("rdata", e, rdata_o)
   endtask

   task automatic setreg(input int i, input logic [7:0] d);
      wr(lodpc_pkg::OFS_FIRST_DIV_LO + 16'(i), d);
      regs[i] = d & msk(i);
   endtask

   task automatic xfer();
      wr(lodpc_pkg::OFS_TRANSFER, 8'h01);
      repeat (4) @(posedge ref_clk_i);
      #1;
   endtask

   task automatic chk_active();
      `CHK("first_ratio", {regs[1][1:0], regs[0]}, first_ratio_o)
      `CHK("second_ratio", {regs[3][1:0], regs[2]}, second_ratio_o)
      `CHK("loop_fb_ratio", {regs[5][1:0], regs[4]}, loop_fb_ratio_o)
      `CHK("pump", exp_pump(regs[6], regs[7]), pump_o)
      `CHK("rx", {regs[8][7:2], ~regs[8][2]}, rx_o)
   endtask

   task automatic edges(input int cnt_e);
      repeat (cnt_e) begin
         @(posedge ref_clk_i);
         pins <= 3'h7;
         repeat (3) @(posedge ref_clk_i);
         pins <= 3'h0;
         repeat (2) @(posedge ref_clk_i);
      end
   endtask

   task automatic finish_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   initial begin
      codes = '{10'h002, 10'h3ff, 10'h000, 10'h000, 10'h001};
      codes[3] = 10'(($random(seed) & 15) + 3);
      repeat (20) @(posedge ref_clk_i);
      resetn_i <= 1'b1;
      #1;
      `CHK("rst_rx", 7'h01, rx_o)
      `CHK("rst_ratio", 10'h000, first_ratio_o)
      `CHK("rst_pump", exp_pump(8'h00, 8'h00), pump_o)
      for (int i = 0; i < 9; i++) rd(lodpc_pkg::OFS_FIRST_DIV_LO + 16'(i), 8'h00);
      for (int i = 0; i < 9; i++) setreg(i, 8'($random(seed)));
      wr(16'h0110, 8'hff);
      rd(16'h0110, 8'h00);
      for (int i = 0; i < 9; i++) rd(lodpc_pkg::OFS_FIRST_DIV_LO + 16'(i), regs[i]);
      `CHK("staged_only", 10'h000, first_ratio_o)
      xfer();
      chk_active();
      rd(lodpc_pkg::OFS_TRANSFER, 8'h00);
      for (int m = 0; m < 8; m++) begin
         setreg(6, 8'(m * 37));
         setreg(7, 8'hdc ^ 8'(m * 33));
         xfer();
         chk_active();
      end
      setreg(8, 8'h18);
      foreach (codes[j]) begin
         for (int k = 0; k < 3; k++) begin
            setreg(2 * k, codes[j][7:0]);
            setreg(2 * k + 1, {6'h00, codes[j][9:8]});
         end
         xfer();
         chk_active();
         b = cnt;
         for (int e = 0; e < 1100 && (cnt[0] == b[0] || cnt[1] == b[1] || cnt[2] == b[2]); e++) edges(1);
         repeat (8) @(posedge ref_clk_i);
         b = cnt;
         n = (codes[j] < 2) ? 1 : int'(codes[j]);
         edges(3 * n);
         repeat (8) @(posedge ref_clk_i);
         for (int k = 0; k < 3; k++) `CHK("pulses", 3, cnt[k] - b[k])
      end
      setreg(8, 8'h10);
      xfer();
      b = cnt;
      edges(4);
      repeat (8) @(posedge ref_clk_i);
      `CHK("gated", 0, cnt[0] - b[0])
      `CHK("open", 4, cnt[1] - b[1])
      finish_test();
   end
endmodule // testbench
